//--- rtl/bcad_decode.sv
// Configuration block and window address decode for a backplane module
`timescale 1ns/10ps
`include "bcad_map.svh"
module bcad_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] la_switch,
  input wire logic opt_32m,
  input wire bcad_pkg::bcad_req_t req,
  output bcad_pkg::bcad_rsp_t rsp,
  output logic op_sel,
  output logic [24:0] op_addr,
  output logic [7:0] la_active,
  output logic dyn_mode
);
  import bcad_pkg::*;
  default clocking cb_chk @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [7:0] sw_sync;
  logic opt_sync;
  logic [7:0] la_reg_ff;
  logic [7:0] nxt_la_reg;
  logic [15:0] offset_ff;
  logic [15:0] nxt_offset;
  bcad_state_t state_ff;
  bcad_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic op_sel_ff;
  logic nxt_op_sel;
  logic [24:0] op_addr_ff;
  logic [24:0] nxt_op_addr;
  logic cfg_hit;
  logic win_hit;
  logic [7:0] win_mask;
  logic [5:0] cfg_off;
  logic [31:0] cfg_word;

  bcad_sync2 #(.W(8)) u_sw (
    .clock(clock),
    .rst(rst),
    .din(la_switch),
    .dout(sw_sync)
  );

  bcad_sync2 #(.W(1)) u_opt (
    .clock(clock),
    .rst(rst),
    .din(opt_32m),
    .dout(opt_sync)
  );

  // Switch of all ones hands the address to software
  assign dyn_mode = (sw_sync == `BCAD_LA_DYNAMIC);
  assign la_active = dyn_mode ? la_reg_ff : sw_sync;

  assign cfg_off = req.addr[5:0];
  assign cfg_hit = req.req && !req.a32
    && (req.addr[15:14] == `BCAD_CFG_PREFIX)
    && (req.addr[13:6] == la_active);
  assign win_mask = opt_sync ? `BCAD_WIN32_MASK : `BCAD_WIN16_MASK;
  assign win_hit = req.req && req.a32
    && ((req.addr[31:24] & win_mask) == (offset_ff[15:8] & win_mask));

  // Configuration read mux, word aligned pairs of 16-bit registers
  always_comb begin
    cfg_word = 32'h0000_0000;
    case ({cfg_off[5:2], 2'b00})
      `BCAD_OFF_ID: begin
        cfg_word = {`BCAD_CLASS_REG, `BCAD_ADDR_SPACE_A32, `BCAD_MAKER_ID,
          4'h0, `BCAD_MODEL_ID};
      end
      `BCAD_OFF_STATUS: begin
        cfg_word = {8'h00, la_active, offset_ff};
      end
      `BCAD_OFF_ATTR: begin
        cfg_word = {{12'h000, opt_sync ? `BCAD_SIZE_32M : `BCAD_SIZE_16M},
          `BCAD_SERIAL_HI};
      end
      `BCAD_OFF_SER_LO: begin
        cfg_word = {`BCAD_SERIAL_LO, 16'h0000};
      end
      default: begin
        cfg_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_la_reg = la_reg_ff;
    nxt_offset = offset_ff;
    nxt_rdata = rdata_ff;
    nxt_op_sel = 1'b0;
    nxt_op_addr = op_addr_ff;
    case (state_ff)
      BCAD_IDLE: begin
        if (cfg_hit) begin
          nxt_state = BCAD_ACK;
          if (req.d32) begin
            nxt_rdata = cfg_word;
          end else begin
            nxt_rdata = {16'h0000,
              cfg_off[1] ? cfg_word[15:0] : cfg_word[31:16]};
          end
          if (req.wr && cfg_off == `BCAD_OFF_ID && dyn_mode) begin
            nxt_la_reg = req.wdata[7:0];
          end
          if (req.wr && cfg_off == `BCAD_OFF_OFFSET) begin
            nxt_offset = req.wdata[15:0];
          end
        end else if (win_hit) begin
          nxt_state = BCAD_ACK;
          nxt_op_sel = 1'b1;
          nxt_op_addr = req.addr[24:0];
          nxt_rdata = 32'h0000_0000;
        end
      end
      BCAD_ACK: begin
        nxt_state = BCAD_DONE;
      end
      BCAD_DONE: begin
        if (!req.req) begin
          nxt_state = BCAD_IDLE;
        end
      end
      default: begin
        nxt_state = BCAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= BCAD_IDLE;
      la_reg_ff <= `BCAD_LA_RESET;
      offset_ff <= `BCAD_OFFSET_RESET;
      rdata_ff <= 32'h0000_0000;
      op_sel_ff <= 1'b0;
      op_addr_ff <= 25'h000_0000;
    end else begin
      state_ff <= nxt_state;
      la_reg_ff <= nxt_la_reg;
      offset_ff <= nxt_offset;
      rdata_ff <= nxt_rdata;
      op_sel_ff <= nxt_op_sel;
      op_addr_ff <= nxt_op_addr;
    end
  end

  assign rsp.ack = (state_ff == BCAD_ACK);
  assign rsp.rdata = rdata_ff;
  assign op_sel = op_sel_ff;
  assign op_addr = op_addr_ff;

  sequence s_cfg_take;
    state_ff == BCAD_IDLE && cfg_hit;
  endsequence
  sequence s_win_take;
    state_ff == BCAD_IDLE && !cfg_hit && win_hit;
  endsequence
  sequence s_ack_one;
    rsp.ack ##1 !rsp.ack;
  endsequence
  sequence s_sel_one;
    op_sel ##1 !op_sel;
  endsequence

  chk_cfg_ack_timing: assert property (s_cfg_take |=> s_ack_one)
    else $error("config access not acknowledged one cycle later");
  chk_foreign_ignored: assert property (
    (state_ff == BCAD_IDLE && req.req && !req.a32
      && req.addr[13:6] != la_active) |=> !rsp.ack)
    else $error("foreign logical address was answered");
  chk_dyn_select: assert property (
    (!$past(rst, 2) && $past(la_switch, 2) == `BCAD_LA_DYNAMIC)
    |-> dyn_mode && la_active == la_reg_ff)
    else $error("dynamic mode not using register address");
  chk_static_select: assert property (
    (!$past(rst, 2) && $past(la_switch, 2) != `BCAD_LA_DYNAMIC)
    |-> !dyn_mode && la_active == $past(la_switch, 2))
    else $error("static mode not using switch address");
  chk_la_write: assert property (
    (s_cfg_take and (req.wr && dyn_mode && cfg_off == `BCAD_OFF_ID))
    |=> la_reg_ff == $past(req.wdata[7:0]))
    else $error("logical address write lost");
  chk_offset_write: assert property (
    (s_cfg_take and (req.wr && cfg_off == `BCAD_OFF_OFFSET))
    |=> offset_ff == $past(req.wdata[15:0]))
    else $error("offset write lost");
  chk_win_select: assert property (s_win_take |=> s_sel_one)
    else $error("window hit did not pulse select");
  chk_win_miss: assert property (
    (state_ff == BCAD_IDLE && !cfg_hit && !win_hit)
    |=> !op_sel && !rsp.ack)
    else $error("select or ack without a hit");
  chk_size_report: assert property (
    (s_cfg_take and (req.d32 && cfg_off[5:2] == 4'h2))
    |=> rsp.rdata[19:16] == ($past(opt_sync) ? `BCAD_SIZE_32M
      : `BCAD_SIZE_16M))
    else $error("memory need misreported");
  chk_d16_lane: assert property (
    (s_cfg_take and !req.d32) |=> rsp.rdata[31:16] == 16'h0000)
    else $error("16-bit read left data in the upper lane");
  chk_rdata_hold: assert property (
    (state_ff != BCAD_IDLE) |=> $stable(rsp.rdata))
    else $error("read data changed before the next access");
endmodule : bcad_decode

//--- rtl/bcad_map.svh
// Address map constants for the backplane configuration address decode
`ifndef BCAD_MAP_SVH
`define BCAD_MAP_SVH
`define BCAD_LA_DYNAMIC 8'hff
`define BCAD_LA_RESET 8'hff
`define BCAD_CFG_PREFIX 2'h3
`define BCAD_OFF_ID 6'h00
`define BCAD_OFF_TYPE 6'h02
`define BCAD_OFF_STATUS 6'h04
`define BCAD_OFF_OFFSET 6'h06
`define BCAD_OFF_ATTR 6'h08
`define BCAD_OFF_SER_HI 6'h0a
`define BCAD_OFF_SER_LO 6'h0c
// Arbitrary identity values
`define BCAD_MAKER_ID 12'h5a5
`define BCAD_MODEL_ID 12'h123
`define BCAD_SERIAL_HI 16'h0000
`define BCAD_SERIAL_LO 16'h0001
`define BCAD_SERIAL {`BCAD_SERIAL_HI, `BCAD_SERIAL_LO}
`define BCAD_CLASS_REG 2'h3
`define BCAD_ADDR_SPACE_A32 2'h1
`define BCAD_SIZE_16M 4'h8
`define BCAD_SIZE_32M 4'h9
`define BCAD_OFFSET_RESET 16'h0000
`define BCAD_WIN16_MASK 8'hff
`define BCAD_WIN32_MASK 8'hfe
`endif

//--- rtl/bcad_pkg.sv
// Types for the backplane configuration address decode
package bcad_pkg;
  typedef enum logic [1:0] {
    BCAD_IDLE = 2'b00,
    BCAD_ACK = 2'b01,
    BCAD_DONE = 2'b11
  } bcad_state_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic a32;
    logic d32;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bcad_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } bcad_rsp_t;
endpackage : bcad_pkg

//--- rtl/bcad_sync2.sv
// Two flip-flop synchroniser for switch inputs
`timescale 1ns/10ps
module bcad_sync2 #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;
  always_comb begin
    nxt_s1 = din;
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end
  assign dout = s2_ff;
endmodule : bcad_sync2

//--- test/bcad_master.sv
// Bus master model standing for the backplane system controller
`timescale 1ns/10ps
module bcad_master (
  input wire logic clock,
  output bcad_pkg::bcad_req_t req,
  input wire bcad_pkg::bcad_rsp_t rsp
);
  import bcad_pkg::*;
  initial req = '0;
  // One single D16 or D32 cycle, held until ack or a bounded wait
  task automatic xfer(input logic wr, a32, d32, input logic [31:0] a, wd,
    output logic ok, output logic [31:0] rd);
    ok = 1'b0;
    rd = '0;
    @(posedge clock);
    req <= '{1'b1, wr, a32, d32, a, wd};
    for (int n = 0; n < 6 && !ok; n++) begin
      @(posedge clock);
      if (rsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = rsp.rdata;
      end
    end
    // Released lines no longer show the last value
    req <= '{1'b0, ~wr, ~a32, ~d32, ~a, ~wd};
    repeat (2) @(posedge clock);
  endtask : xfer
endmodule : bcad_master

//--- test/backplane_config_address_decode_tb.sv
// Self-checking bench for the backplane configuration address decode
`timescale 1ns/10ps
`include "bcad_map.svh"
module backplane_config_address_decode_tb;
  import bcad_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] la_switch = 8'h01;
  logic opt_32m = 1'b0;
  bcad_req_t req;
  bcad_rsp_t rsp;
  logic op_sel, dyn_mode, ok;
  logic [24:0] op_addr, op_seen;
  logic [7:0] la_active, la;
  logic [15:0] off, hi;
  logic [31:0] rd, a;
  int error_cnt = 0;
  int n_checks = 0;
  int n_op = 0;
  initial forever #10 clock = ~clock;
  bcad_decode bcad_decode_i (.clock(clock), .rst(rst), .la_switch(la_switch),
    .opt_32m(opt_32m), .req(req), .rsp(rsp), .op_sel(op_sel),
    .op_addr(op_addr), .la_active(la_active), .dyn_mode(dyn_mode));
  bcad_master bcad_master_i (.clock(clock), .req(req), .rsp(rsp));
  always @(posedge clock) if (op_sel === 1'b1) begin
    op_seen <= op_addr;
    n_op <= n_op + 1;
  end
  function automatic logic [31:0] cfg(input logic [7:0] l, input logic [5:0] o);
    return {16'h0000, `BCAD_CFG_PREFIX, l, o};
  endfunction : cfg
  function automatic logic [3:0] size_code(input logic big);
    return big ? `BCAD_SIZE_32M : `BCAD_SIZE_16M;
  endfunction : size_code
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic go(input logic w, a32, d32, input logic [31:0] ad, wd);
    bcad_master_i.xfer(w, a32, d32, ad, wd, ok, rd);
  endtask : go
  task automatic finish_test;
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    #(20 * 4000);
    error_cnt++;
    finish_test;
  end
  initial begin
    void'($urandom(66));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      la = (i == 0) ? 8'h01 : (i == 1) ? 8'hfe : 8'($urandom_range(254, 1));
      la_switch <= la;
      opt_32m <= i[0];
      repeat (4) @(posedge clock);
      chk("la_active", {24'h0, la_active}, {24'h0, la});
      chk("dyn_mode", {31'h0, dyn_mode}, 32'h0);
      go('0, '0, '0, cfg(la, `BCAD_OFF_ID), '0);
      chk("id", {16'h0, rd[15:0]}, {16'h0, `BCAD_CLASS_REG,
        `BCAD_ADDR_SPACE_A32, `BCAD_MAKER_ID});
      go('0, '0, '0, cfg(la, `BCAD_OFF_SER_HI), '0);
      hi = rd[15:0];
      go('0, '0, '0, cfg(la, `BCAD_OFF_SER_LO), '0);
      chk("serial", {hi, rd[15:0]}, `BCAD_SERIAL);
      go('0, '0, '1, cfg(la, `BCAD_OFF_ATTR), '0);
      chk("size", {28'h0, rd[19:16]}, {28'h0, size_code(i[0])});
      chk("serial d32", {16'h0, rd[15:0]}, {16'h0, `BCAD_SERIAL_HI});
      go('0, '0, '0, cfg(la, 6'h3e), '0);
      chk("spare", {15'h0, ok, rd[15:0]}, {15'h0, 1'b1, 16'h0});
      go('0, '0, '0, cfg(la ^ 8'h80, `BCAD_OFF_ID), '0);
      chk("foreign ack", {31'h0, ok}, 32'h0);
      go('0, '0, '0, cfg(la, `BCAD_OFF_ID) ^ 32'h4000, '0);
      chk("prefix ack", {31'h0, ok}, 32'h0);
      go('1, '0, '0, cfg(la, `BCAD_OFF_ID), 32'h33);
      chk("static la", {24'h0, la_active}, {24'h0, la});
      off = 16'($urandom());
      go('1, '0, '0, cfg(la, `BCAD_OFF_OFFSET), {16'h0, off});
      go('0, '0, '1, cfg(la, `BCAD_OFF_STATUS), '0);
      chk("offset d32", {16'h0, rd[15:0]}, {16'h0, off});
      a = {off[15:8], 24'($urandom())};
      go('0, '1, '1, a, '0);
      @(posedge clock);
      chk("a32 ack", {31'h0, ok}, 32'h1);
      chk("op_addr", {7'h0, op_seen}, {7'h0, a[24:0]});
      go('0, '1, '0, a ^ 32'h0100_0000, '0);
      chk("a32 size", {31'h0, ok}, {31'h0, i[0]});
      go('0, '1, '0, a ^ 32'h0200_0000, '0);
      chk("a32 miss", {31'h0, ok}, 32'h0);
    end
    chk("op count", n_op, 6);
    la_switch <= `BCAD_LA_DYNAMIC;
    repeat (4) @(posedge clock);
    chk("dyn_mode", {31'h0, dyn_mode}, 32'h1);
    chk("la reset", {24'h0, la_active}, {24'h0, `BCAD_LA_RESET});
    la = 8'($urandom_range(254, 1));
    go('1, '0, '0, cfg(`BCAD_LA_DYNAMIC, `BCAD_OFF_ID), {24'h0, la});
    chk("dyn la", {24'h0, la_active}, {24'h0, la});
    go('0, '0, '0, cfg(la, `BCAD_OFF_SER_LO), '0);
    chk("moved", {15'h0, ok, rd[15:0]}, {15'h0, 1'b1, `BCAD_SERIAL_LO});
    go('0, '0, '0, cfg(`BCAD_LA_DYNAMIC, `BCAD_OFF_SER_LO), '0);
    chk("old base", {31'h0, ok}, 32'h0);
    finish_test;
  end
endmodule : backplane_config_address_decode_tb
